// File: verilog/nsdp_pkg.sv
// Shared constants and types for the synchronous DDR bus port of a NAND target.
// Assumes a 10 MHz system clock and a host that supplies the link clock.
//
// Contract
// RULE1 - Latch command byte on CLE-only write cycle.
// RULE2 - Host idles bus after each command/address.
// RULE3 - Busy unit ignores commands except status ones.
// RULE4 - Latch address byte on ALE-only write cycle.
// RULE5 - Host zeroes unused address bits, sends counts.
// RULE6 - Busy unit ignores addresses except after select.
// RULE7 - Host enters data input with strobe low.
// RULE8 - Write cache on every strobe edge.
// RULE9 - Host ends input with both enables low.
// RULE10 - Strobe postamble low, then bus idles.
// RULE11 - Unselected or busy unit discards input data.
// RULE12 - Array data only when ready after read.
// RULE13 - Device takes bus after direction latched low.
// RULE14 - Output strobe follows clock, data edge-aligned.
// RULE15 - Output continues while enables sampled high.
// RULE16 - Last pair follows last enables-high cycle.
// RULE17 - After turnaround bus is idle again.
// RULE18 - Busy unit outputs only status contents.
// RULE19 - Direction high releases bus; low drives strobe low.
// RULE20 - Host waits for ready before first reset.
// RULE21 - Reset command keeps target busy bounded time.
// RULE22 - Synchronous protocol off until explicitly enabled.
// RULE23 - Direction high means idle, pins are inputs.
// RULE24 - Direction low means device owns the bus.
// RULE25 - Host counts delays in whole clock cycles.

package nsdp_pkg;

  // ****************************************************************
  // Commands that matter to the port itself
  // ****************************************************************
  localparam logic [7:0] CMD_RESET = 8'hff;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_SELECT = 8'h78;

  // ****************************************************************
  // Status byte layout and reset values
  // ****************************************************************
  localparam int STAT_READY_BIT = 6;
  localparam int STAT_ARRAY_BIT = 5;
  localparam logic [7:0] STAT_ZERO = 8'h00;
  localparam logic [7:0] UNIT_ADDR_RST = 8'h00;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int SYS_CLK_KHZ = 10000;
  localparam int POR_BUSY_US = 1000;
  localparam int KHZ_PER_MHZ = 1000;

  // ****************************************************************
  // Link state machine
  // ****************************************************************
  typedef enum logic [2:0] {
    LS_IDLE = 3'b001,
    LS_DIN = 3'b010,
    LS_DOUT = 3'b100
  } nsdp_link_state_t;

endpackage : nsdp_pkg

// File: verilog/nsdp_cache_mem.sv
// Cache register storage: one word holds a rising/falling byte pair.
// Assumes a single clock for both ports; read data are registered.
`timescale 1ns/1ps

module nsdp_cache_mem #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 64,
  parameter int AW = $clog2(DEPTH)
) (
  // Clock
  input wire logic clk_in,
  // Write port
  input wire logic we_in,
  input wire logic [AW-1:0] waddr_in,
  input wire logic [WIDTH-1:0] wdata_in,
  // Read port
  input wire logic [AW-1:0] raddr_in,
  output logic [WIDTH-1:0] rdata_out
);

  logic [WIDTH-1:0] mem [DEPTH];

  // Write and registered read share the edge; a same-address read sees old data.
  always_ff @(posedge clk_in)
  begin
    if (we_in)
    begin
      mem[waddr_in] <= wdata_in;
    end
    rdata_out <= mem[raddr_in];
  end

endmodule : nsdp_cache_mem

// File: verilog/nsdp_bus_port.sv
// Target-side synchronous DDR bus port with busy handling and reset busy time.
// Assumes the host drives the link clock, enables and direction; strobe is
// mesochronous with the link clock, and the flash core runs on sys_clk_in.
`timescale 1ns/1ps

module nsdp_bus_port #(
  parameter int POR_BUSY_CYCLES =
    nsdp_pkg::POR_BUSY_US * nsdp_pkg::SYS_CLK_KHZ / nsdp_pkg::KHZ_PER_MHZ,
  parameter int CACHE_DEPTH = 64,
  parameter logic [7:0] UNIT_ADDR = nsdp_pkg::UNIT_ADDR_RST
) (
  // System clock and reset
  input wire logic sys_clk_in,
  input wire logic srst_in,
  // Link pins from the host
  input wire logic link_clk_in,
  input wire logic chip_select_n_in,
  input wire logic cmd_latch_in,
  input wire logic addr_latch_in,
  input wire logic bus_dir_in,
  input wire logic [7:0] dq_in,
  input wire logic dqs_in,
  // Link pins toward the host
  output logic [7:0] dq_out,
  output logic dq_oe_out,
  output logic dqs_out,
  output logic dqs_oe_out,
  output logic ready_busy_n_out,
  output logic ready_busy_n_oe_out,
  // Flash core side
  input wire logic sync_enable_in,
  input wire logic core_busy_in,
  input wire logic read_done_in,
  output logic cmd_valid_out,
  output logic [7:0] cmd_byte_out,
  output logic addr_valid_out,
  output logic [7:0] addr_byte_out
);

  localparam int AW = $clog2(CACHE_DEPTH);
  localparam int PW = $clog2(POR_BUSY_CYCLES + 1);

  // ****************************************************************
  // System domain: crossings in, reset busy time, ready flags
  // ****************************************************************
  logic [2:0] cmd_tog_s;
  logic [2:0] addr_tog_s;
  logic [PW-1:0] por_cnt;
  logic busy;
  logic data_ready;
  logic cmd_tog;
  logic addr_tog;
  logic [7:0] cmd_reg;
  logic [7:0] addr_reg;

  wire cmd_event = cmd_tog_s[2] ^ cmd_tog_s[1];
  wire addr_event = addr_tog_s[2] ^ addr_tog_s[1];
  wire reset_event = cmd_event && (cmd_reg == nsdp_pkg::CMD_RESET);
  wire next_busy = (por_cnt != '0) || reset_event || core_busy_in;

  // Toggle synchronisers; the held byte is stable because the host idles the bus.
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      cmd_tog_s <= 3'b000;
      addr_tog_s <= 3'b000;
    end
    else
    begin
      cmd_tog_s <= {cmd_tog_s[1:0], cmd_tog};
      addr_tog_s <= {addr_tog_s[1:0], addr_tog};
    end
  end

  // Bytes to the core; the link registers are quiet once an event is seen.
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      cmd_valid_out <= 1'b0;
      cmd_byte_out <= nsdp_pkg::STAT_ZERO;
      addr_valid_out <= 1'b0;
      addr_byte_out <= nsdp_pkg::STAT_ZERO;
    end
    else
    begin
      cmd_valid_out <= cmd_event;
      addr_valid_out <= addr_event;
      cmd_byte_out <= cmd_event ? cmd_reg : cmd_byte_out;
      addr_byte_out <= addr_event ? addr_reg : addr_byte_out;
    end
  end

  // Reset busy counter, busy line and array-data flag; a read completion wins
  // over a clear by a new command in the same cycle.
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      por_cnt <= '0;
      busy <= 1'b0;
      data_ready <= 1'b0;
      ready_busy_n_out <= 1'b0;
      ready_busy_n_oe_out <= 1'b0;
    end
    else
    begin
      por_cnt <= reset_event ? PW'(POR_BUSY_CYCLES) : // [RULE21]
                 (por_cnt != '0) ? por_cnt - PW'(1) : por_cnt;
      busy <= next_busy;
      data_ready <= read_done_in || (data_ready && !cmd_event); // [RULE12]
      ready_busy_n_oe_out <= next_busy; // [RULE21]
    end
  end

  a_por_busy_line: assert property (@(posedge sys_clk_in) disable iff (srst_in) // [RULE21]
    (por_cnt != '0) |-> ready_busy_n_oe_out && !ready_busy_n_out)
    else $error("Reset busy time not shown on ready/busy line.");

  a_por_bound: assert property (@(posedge sys_clk_in) disable iff (srst_in) // [RULE21]
    $rose(por_cnt != '0) |-> por_cnt == PW'(POR_BUSY_CYCLES))
    else $error("Reset busy time has the wrong length.");

  // ****************************************************************
  // Link domain: reset and level crossings from the system side
  // ****************************************************************
  logic [1:0] link_rst_s;
  logic [1:0] busy_s;
  logic [1:0] ready_s;
  logic [1:0] sync_en_s;
  wire link_rst = link_rst_s[1];
  wire busy_l = busy_s[1];
  wire ready_l = ready_s[1];
  wire sync_en_l = sync_en_s[1];

  // Two-flop synchronisers without reset; synchronous mode follows sync_enable_in alone.
  always_ff @(posedge link_clk_in)
  begin
    link_rst_s <= {link_rst_s[0], srst_in};
    busy_s <= {busy_s[0], busy};
    ready_s <= {ready_s[0], data_ready};
    sync_en_s <= {sync_en_s[0], sync_enable_in}; // [RULE22]
  end

  // ****************************************************************
  // Link domain: cycle decode
  // ****************************************************************
  nsdp_pkg::nsdp_link_state_t state;
  nsdp_pkg::nsdp_link_state_t next_state;
  logic status_mode;
  logic after_select;
  logic selected;
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic w_d1;
  logic w_d2;
  logic rt;
  logic ft;
  logic [15:0] out_pair;
  logic [7:0] fall_byte;
  logic [7:0] din_rise;
  logic [7:0] din_fall;
  logic [15:0] mem_rdata;

  wire selected_go = !chip_select_n_in && sync_en_l; // [RULE22]
  wire cmd_cycle = selected_go && cmd_latch_in && !addr_latch_in && bus_dir_in;
  wire addr_cycle = selected_go && addr_latch_in && !cmd_latch_in && bus_dir_in;
  wire is_status_cmd = (dq_in == nsdp_pkg::CMD_STATUS) || (dq_in == nsdp_pkg::CMD_SELECT);
  wire cmd_take = cmd_cycle && (!busy_l || is_status_cmd); // [RULE3]
  wire addr_take = addr_cycle && (!busy_l || after_select); // [RULE6]
  // The strobe must be low to enter; once inside it is free to toggle.
  wire din_cycle = selected_go && cmd_latch_in && addr_latch_in && bus_dir_in &&
                   ((state == nsdp_pkg::LS_DIN) || !dqs_in); // [RULE7]
  wire out_allowed = status_mode || (!busy_l && ready_l && selected); // [RULE12] [RULE18]
  wire dout_cycle = selected_go && cmd_latch_in && addr_latch_in && !bus_dir_in &&
                    out_allowed; // [RULE15]
  wire mem_we = w_d2 && selected && !busy_l; // [RULE11]
  wire [AW-1:0] next_rd_ptr = cmd_take ? '0 :
                              (dout_cycle && !status_mode) ? rd_ptr + AW'(1) : rd_ptr;
  wire [7:0] status_byte = nsdp_pkg::STAT_ZERO | (8'(!busy_l) << nsdp_pkg::STAT_READY_BIT) |
                           (8'(ready_l) << nsdp_pkg::STAT_ARRAY_BIT);
  // Direction low with the target enabled hands the bus to the selected unit.
  wire owner = !chip_select_n_in && !bus_dir_in && selected && sync_en_l; // [RULE24]

  assign next_state = din_cycle ? nsdp_pkg::LS_DIN :
                      dout_cycle ? nsdp_pkg::LS_DOUT : nsdp_pkg::LS_IDLE;

  // ****************************************************************
  // Link domain: command, address and selection registers
  // ****************************************************************
  always_ff @(posedge link_clk_in)
  begin
    if (link_rst)
    begin
      cmd_reg <= nsdp_pkg::STAT_ZERO;
      cmd_tog <= 1'b0;
      addr_reg <= nsdp_pkg::STAT_ZERO;
      addr_tog <= 1'b0;
    end
    else
    begin
      cmd_reg <= cmd_take ? dq_in : cmd_reg; // [RULE1]
      cmd_tog <= cmd_tog ^ cmd_take; // [RULE1]
      addr_reg <= addr_take ? dq_in : addr_reg; // [RULE4]
      addr_tog <= addr_tog ^ addr_take; // [RULE4]
    end
  end

  // Status mode lasts until the next command; the last select address byte
  // names the unit, so a full select sequence leaves the right answer.
  always_ff @(posedge link_clk_in)
  begin
    if (link_rst)
    begin
      status_mode <= 1'b0;
      after_select <= 1'b0;
      selected <= 1'b1;
    end
    else
    begin
      status_mode <= cmd_take ? is_status_cmd : status_mode; // [RULE18]
      after_select <= cmd_take ? (dq_in == nsdp_pkg::CMD_SELECT) : after_select;
      selected <= (addr_take && after_select) ? (dq_in == UNIT_ADDR) : selected;
    end
  end

  a_cmd_capture: assert property (@(posedge link_clk_in) disable iff (link_rst) // [RULE1]
    cmd_take |=> (cmd_reg == $past(dq_in)) && (cmd_tog != $past(cmd_tog)))
    else $error("Command byte not captured.");

  a_busy_cmd_drop: assert property (@(posedge link_clk_in) disable iff (link_rst) // [RULE3]
    (cmd_cycle && busy_l && !is_status_cmd) |=> $stable(cmd_tog))
    else $error("Busy unit accepted a non-status command.");

  a_addr_capture: assert property (@(posedge link_clk_in) disable iff (link_rst) // [RULE4]
    addr_take |=> (addr_reg == $past(dq_in)) && (addr_tog != $past(addr_tog)))
    else $error("Address byte not captured.");

  a_busy_addr_drop: assert property (@(posedge link_clk_in) disable iff (link_rst) // [RULE6]
    (addr_cycle && busy_l && !after_select) |=> $stable(addr_tog))
    else $error("Busy unit accepted an address byte.");

  a_async_gate: assert property (@(posedge link_clk_in) disable iff (link_rst) // [RULE22]
    !sync_en_l |-> !cmd_take && !addr_take && !din_cycle && !dout_cycle)
    else $error("Link cycle taken before synchronous mode enabled.");

  // ****************************************************************
  // Link domain: data input
  // ****************************************************************
  // Bytes land on both strobe edges; the pair is complete two link cycles after
  // the enables-high cycle that launched it, which also covers the final pair.
  always_ff @(posedge dqs_in)
  begin
    din_rise <= dq_in; // [RULE8]
  end

  always_ff @(negedge dqs_in)
  begin
    din_fall <= dq_in; // [RULE8]
  end

  // Pair pipeline, write pointer and link state; after the postamble the
  // state is already idle, so the next cycle decodes normally.
  always_ff @(posedge link_clk_in)
  begin
    if (link_rst)
    begin
      state <= nsdp_pkg::LS_IDLE;
      w_d1 <= 1'b0;
      w_d2 <= 1'b0;
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      state <= next_state; // [RULE10] [RULE17]
      w_d1 <= din_cycle; // [RULE9]
      w_d2 <= w_d1;
      wr_ptr <= cmd_take ? '0 : mem_we ? wr_ptr + AW'(1) : wr_ptr; // [RULE8]
      rd_ptr <= next_rd_ptr;
    end
  end

  a_din_write: assert property (@(posedge link_clk_in) disable iff (link_rst) // [RULE8]
    ($past(din_cycle, 2) && selected && !busy_l && !cmd_take) |=>
      wr_ptr == $past(wr_ptr) + AW'(1))
    else $error("Input pair not written to cache.");

  a_din_discard: assert property (@(posedge link_clk_in) disable iff (link_rst) // [RULE11]
    (!selected || busy_l) && !cmd_take |=> $stable(wr_ptr))
    else $error("Unselected or busy unit kept input data.");

  nsdp_cache_mem #(
    .WIDTH(16),
    .DEPTH(CACHE_DEPTH),
    .AW(AW)
  ) u_cache (
    .clk_in(link_clk_in),
    .we_in(mem_we),
    .waddr_in(wr_ptr),
    .wdata_in({din_fall, din_rise}),
    .raddr_in(next_rd_ptr),
    .rdata_out(mem_rdata)
  );

  // ****************************************************************
  // Link domain: data output and pin drivers
  // ****************************************************************
  // Rising edge: load the pair and toggle the strobe high; the strobe falls at
  // the following falling edge, so both strobe edges trail the clock edges.
  always_ff @(posedge link_clk_in)
  begin
    if (link_rst)
    begin
      rt <= 1'b0;
      out_pair <= 16'h0000;
      dq_oe_out <= 1'b0;
      dqs_oe_out <= 1'b0;
    end
    else
    begin
      rt <= rt ^ dout_cycle; // [RULE14] [RULE16]
      out_pair <= !dout_cycle ? out_pair : // [RULE19]
                  status_mode ? {status_byte, status_byte} : mem_rdata; // [RULE12]
      dq_oe_out <= owner; // [RULE13] [RULE19] [RULE23]
      dqs_oe_out <= owner; // [RULE13] [RULE19] [RULE23]
    end
  end

  // Falling edge closes the strobe pulse and presents the second byte.
  always_ff @(negedge link_clk_in)
  begin
    if (link_rst)
    begin
      ft <= 1'b0;
      fall_byte <= 8'h00;
    end
    else
    begin
      ft <= rt; // [RULE14]
      fall_byte <= out_pair[15:8];
    end
  end

  // Data change with each strobe edge, so they stay edge-aligned; outside a
  // burst the strobe rests low and the last byte stays on the pins.
  assign dqs_out = rt ^ ft; // [RULE14] [RULE19]
  assign dq_out = dqs_out ? out_pair[7:0] : fall_byte; // [RULE14]

  a_strobe_toggle: assert property (@(posedge link_clk_in) disable iff (link_rst) // [RULE14]
    (state == nsdp_pkg::LS_DOUT) |-> (rt != $past(rt)) && (ft == rt))
    else $error("Output strobe did not follow the clock.");

  a_output_end: assert property (@(posedge link_clk_in) disable iff (link_rst) // [RULE16]
    (!$past(dout_cycle) && !dout_cycle) |=> $stable(rt))
    else $error("Strobe kept toggling after output ended.");

  a_dout_ready: assert property (@(posedge link_clk_in) disable iff (link_rst) // [RULE18]
    ((state == nsdp_pkg::LS_DOUT) && !$past(status_mode)) |->
      $past(ready_l) && !$past(busy_l) && $past(selected))
    else $error("Array data given by a busy or unready unit.");

  a_release_bus: assert property (@(posedge link_clk_in) disable iff (link_rst) // [RULE19]
    bus_dir_in |=> !dq_oe_out && !dqs_oe_out)
    else $error("Bus not released when direction went high.");

endmodule : nsdp_bus_port

// File: dv/nsdp_host_model.sv
// Host controller model for the synchronous DDR bus port.
// Assumes the bench resolves the shared dq and dqs wires from both enables.
`timescale 1ns/1ps

module nsdp_host_model (
  // Link pins driven by the host
  output logic link_clk_out,
  output logic cs_n_out,
  output logic cle_out,
  output logic ale_out,
  output logic dir_out,
  output logic [7:0] dq_out,
  output logic dqs_out,
  output logic drive_out,
  // Device pins seen by the host
  input wire logic [7:0] dev_dq_in,
  input wire logic dev_dqs_in,
  input wire logic dev_oe_in
);
  // ****************************************************************
  // Host state and captured output bytes
  // ****************************************************************
  logic [7:0] rx_q [$];
  logic oe_on;
  logic oe_hold;
  logic oe_off;

  // The link clock keeps running since the target stays enabled throughout.
  initial
  begin
    link_clk_out = 1'b0;
    cs_n_out = 1'b0;
    cle_out = 1'b0;
    ale_out = 1'b0;
    dir_out = 1'b1;
    dq_out = 8'h00;
    dqs_out = 1'b0;
    drive_out = 1'b1;
    #1.7;
    forever #3 link_clk_out = ~link_clk_out;
  end

  // A released bus shows a changing pattern, never a stale value.
  always @(negedge link_clk_out)
    if (!drive_out)
      dq_out <= ~dq_out;

  // Each strobe edge from the device carries one byte.
  always @(posedge dev_dqs_in) #1 rx_q.push_back(dev_dq_in);
  always @(negedge dev_dqs_in) #1 rx_q.push_back(dev_dq_in);

  // One command or address cycle, with the bus idle on the next rise.
  task automatic cycle(input logic is_addr, input logic [7:0] b);
    @(negedge link_clk_out);
    cle_out = !is_addr;
    ale_out = is_addr;
    dq_out = b;
    @(negedge link_clk_out);
    cle_out = 1'b0;
    ale_out = 1'b0;
    dq_out = ~b;
  endtask : cycle

  // Two byte pairs of data input, centre aligned to the strobe.
  task automatic din(input logic [7:0] b [4]);
    @(negedge link_clk_out);
    cle_out = 1'b1;
    ale_out = 1'b1;
    dqs_out = 1'b0;
    @(posedge link_clk_out);
    for (int k = 0; k < 2; k++)
    begin
      @(negedge link_clk_out);
      dqs_out = 1'b0;
      if (k == 1)
      begin
        cle_out = 1'b0;
        ale_out = 1'b0;
      end
      // Data move off the strobe edge, so the falling capture still sees the old byte.
      #1.5 dq_out = b[2*k];
      @(posedge link_clk_out);
      #0.5 dqs_out = 1'b1;
      #1.5 dq_out = b[2*k+1];
    end
    @(negedge link_clk_out);
    dqs_out = 1'b0;
    repeat (2) @(negedge link_clk_out);
  endtask : din

  // Data output for n clock cycles, then the bus is handed back.
  task automatic dout(input int n);
    rx_q.delete();
    @(negedge link_clk_out);
    drive_out = 1'b0;
    @(negedge link_clk_out);
    dir_out = 1'b0;
    @(posedge link_clk_out);
    @(posedge link_clk_out);
    #1 oe_on = dev_oe_in;
    @(negedge link_clk_out);
    cle_out = 1'b1;
    ale_out = 1'b1;
    repeat (n) @(negedge link_clk_out);
    cle_out = 1'b0;
    ale_out = 1'b0;
    repeat (3) @(negedge link_clk_out);
    oe_hold = dev_oe_in;
    dir_out = 1'b1;
    @(posedge link_clk_out);
    @(posedge link_clk_out);
    #1 oe_off = dev_oe_in;
    @(negedge link_clk_out);
    drive_out = 1'b1;
    dqs_out = 1'b0;
  endtask : dout
endmodule : nsdp_host_model

// File: dv/tb.sv
// Self-checking bench for the synchronous DDR bus port.
// Assumes the port and the host model are compiled before it.
`timescale 1ns/1ps

module tb;
  // ****************************************************************
  // Pins, wires and counters
  // ****************************************************************
  localparam int POR = 20;
  logic sys_clk_in;
  logic srst_in;
  logic sync_enable_in;
  logic core_busy_in;
  logic read_done_in;
  logic lclk, cs_n, cle, ale, dir, h_dqs, h_drv;
  logic [7:0] h_dq, dq_o, dq_w, cb, ab;
  logic dq_oe, dqs_o, dqs_oe, dqs_w, rbn, rbn_oe, cv, av;
  logic [7:0] pat_a [4] = '{8'h11, 8'h2c, 8'hd3, 8'hee};
  logic [7:0] pat_b [4] = '{8'h5a, 8'ha5, 8'h0f, 8'hf0};
  int n_fail = 0;
  int n_checks = 0;

  // The shared pins carry whichever party has its enable raised.
  assign dq_w = dq_oe ? dq_o : h_dq;
  assign dqs_w = dqs_oe ? dqs_o : (h_drv ? h_dqs : ~h_dqs);

  nsdp_host_model host (.link_clk_out(lclk), .cs_n_out(cs_n), .cle_out(cle), .ale_out(ale),
    .dir_out(dir), .dq_out(h_dq), .dqs_out(h_dqs), .drive_out(h_drv),
    .dev_dq_in(dq_o), .dev_dqs_in(dqs_o), .dev_oe_in(dq_oe));

  nsdp_bus_port #(.POR_BUSY_CYCLES(POR)) dut (.sys_clk_in(sys_clk_in), .srst_in(srst_in),
    .link_clk_in(lclk), .chip_select_n_in(cs_n), .cmd_latch_in(cle), .addr_latch_in(ale),
    .bus_dir_in(dir), .dq_in(dq_w), .dqs_in(dqs_w), .dq_out(dq_o), .dq_oe_out(dq_oe),
    .dqs_out(dqs_o), .dqs_oe_out(dqs_oe), .ready_busy_n_out(rbn),
    .ready_busy_n_oe_out(rbn_oe), .sync_enable_in(sync_enable_in),
    .core_busy_in(core_busy_in), .read_done_in(read_done_in), .cmd_valid_out(cv),
    .cmd_byte_out(cb), .addr_valid_out(av), .addr_byte_out(ab));

  initial
  begin
    sys_clk_in = 1'b0;
    forever #50 sys_clk_in = ~sys_clk_in;
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // Sends one byte and watches the core side for its pulse.
  task automatic send(input logic is_addr, input logic [7:0] b, input logic exp);
    logic seen;
    seen = 1'b0;
    host.cycle(is_addr, b);
    repeat (20)
    begin
      @(negedge sys_clk_in);
      if ((is_addr ? av : cv) === 1'b1)
        seen = 1'b1;
    end
    check({7'h00, seen}, {7'h00, exp});
    if (exp)
      check(is_addr ? ab : cb, b);
  endtask : send

  task automatic settle(input logic busy);
    @(negedge sys_clk_in);
    core_busy_in = busy;
    repeat (4) @(negedge sys_clk_in);
  endtask : settle

  task automatic read_back(input logic [7:0] exp [4]);
    send(1'b0, 8'h00, 1'b1);
    @(negedge sys_clk_in);
    read_done_in = 1'b1;
    @(negedge sys_clk_in);
    read_done_in = 1'b0;
    host.dout(2);
    check(8'(host.rx_q.size()), 8'h04);
    for (int i = 0; i < 4; i++)
      check(host.rx_q[i], exp[i]);
  endtask : read_back

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_por;
    int cnt;
    cnt = 0;
    send(1'b0, 8'hff, 1'b0);
    sync_enable_in = 1'b1;
    repeat (3) @(negedge sys_clk_in);
    check({7'h00, rbn_oe}, 8'h00);
    host.cycle(1'b0, 8'hff);
    repeat (10)
      if (cv !== 1'b1)
        @(negedge sys_clk_in);
    while (rbn_oe === 1'b1 && cnt < 100)
    begin
      cnt++;
      @(negedge sys_clk_in);
    end
    check(8'(cnt), 8'(POR + 1));
    check({7'h00, rbn}, 8'h00);
  endtask : t_por

  task automatic t_busy;
    send(1'b0, 8'h90, 1'b1);
    send(1'b1, 8'h00, 1'b1);
    settle(1'b1);
    send(1'b0, 8'h90, 1'b0);
    send(1'b0, 8'h70, 1'b1);
    send(1'b1, 8'h12, 1'b0);
    send(1'b0, 8'h78, 1'b1);
    repeat (3) send(1'b1, 8'h00, 1'b1);
    settle(1'b0);
  endtask : t_busy

  task automatic t_write_read;
    send(1'b0, 8'h80, 1'b1);
    host.din(pat_a);
    send(1'b0, 8'h00, 1'b1);
    host.dout(1);
    check(8'(host.rx_q.size()), 8'h00);
    read_back(pat_a);
    check({7'h00, host.oe_on}, 8'h01);
    check({7'h00, host.oe_hold}, 8'h01);
    check({7'h00, host.oe_off}, 8'h00);
    check({7'h00, dqs_oe}, 8'h00);
  endtask : t_write_read

  task automatic t_busy_io;
    settle(1'b1);
    host.din(pat_b);
    host.dout(1);
    check(8'(host.rx_q.size()), 8'h00);
    send(1'b0, 8'h70, 1'b1);
    host.dout(1);
    check(8'(host.rx_q.size()), 8'h02);
    // Busy and freshly commanded: neither the ready bit nor the array bit is set.
    check(host.rx_q[0], 8'h00);
    check(host.rx_q[1], 8'h00);
    settle(1'b0);
    read_back(pat_a);
  endtask : t_busy_io

  task automatic results;
    $display("checks=%0d failures=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results

  // Main sequence: the first accepted command is the reset command.
  initial
  begin
    srst_in = 1'b1;
    sync_enable_in = 1'b0;
    core_busy_in = 1'b0;
    read_done_in = 1'b0;
    repeat (3) @(negedge sys_clk_in);
    srst_in = 1'b0;
    repeat (2) @(negedge sys_clk_in);
    t_por;
    t_busy;
    t_write_read;
    t_busy_io;
    results;
  end

  // The sequence needs well under two hundred microseconds.
  initial
  begin
    #200_000;
    n_fail++;
    results;
  end
endmodule : tb
